// ==== rtl/clock_switch_pkg.sv ====
// shared constants and types for the glitchless clock switchover
`default_nettype none
package clock_switch_pkg;
  localparam int unsigned CLK_SYS_HZ       = 25_000_000;
  // pulses of the old clock still passed before the hold phase
  localparam logic [3:0]  DRAIN_PULSES     = 4'h2;
  // new-clock edges counted in each hold phase
  localparam logic [3:0]  HOLD_PULSES      = 4'h2;
  // sample cycles without an edge before a source is called stuck
  localparam logic [7:0]  STUCK_CYCLES     = 8'h08;
  // worst-case new-clock cycles from select change to following
  localparam logic [4:0]  MAX_SWITCH_EDGES = 5'h11;
  localparam logic        OUT_RESET_LEVEL  = 1'b0;

  typedef enum logic [1:0] {
    ST_FOLLOW,
    ST_DRAIN,
    ST_HOLD_HIGH,
    ST_HOLD_LOW
  } switch_state_e;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
    logic stuck;
  } src_stat_s;
endpackage : clock_switch_pkg
`default_nettype wire

// ==== rtl/failsafe_input_latch.sv ====
// fail-safe latch and activity monitor for one clock source
`default_nettype none
module failsafe_input_latch
  import clock_switch_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic srcLevel,
  input  wire logic srcValid,
  output src_stat_s stat
);
  logic       level_r;
  logic       prev_r;
  logic [7:0] idle_r;

  // collapsed swing keeps the last valid level, never a floating one
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      level_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      if (srcValid)
        level_r <= srcLevel;
      prev_r <= level_r;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      idle_r <= 8'h00;
    else if (level_r != prev_r)
      idle_r <= 8'h00;
    else if (idle_r != STUCK_CYCLES)
      idle_r <= idle_r + 8'h01;
  end

  // one driver for the whole struct
  assign stat = '{level: level_r,
                  rise:  level_r & ~prev_r,
                  fall:  ~level_r & prev_r,
                  stuck: (idle_r == STUCK_CYCLES)};
endmodule : failsafe_input_latch
`default_nettype wire

// ==== rtl/glitchless_clock_switchover.sv ====
// glitch-free 2:1 clock selection with synchronous output gate
`default_nettype none
// Notes on behaviour
// - stretched switchover cycle keeps its low phase over half new period; the high phase too on the stuck-high path.
// - old clock stuck low: output low for some new falls, then follow.
// - collapsed old clock takes stuck-high or stuck-low path by last level.
// - dead selected input gives a stable output level, never undefined.
// - slowly degrading, still toggling inputs may show runts.
// - enable is synchronised so outputs start or stop only while low.
// - after enable falls, follow until next falling edge, then hold low.
// - after enable rises, resume following only after next falling edge.
// - power-on reset puts the switchover logic in a defined state.
// - running clocks: follow old, hold low on new pulses, then follow new.
// - old stuck high: hold high for new pulses, low for falls, then follow.
// - output follows new clock within 17 input cycles of select change.
// - strapped delay capacitor pin makes the selector a plain multiplexer.
module glitchless_clock_switchover
  import clock_switch_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [1:0] clockSource,
  input  wire logic [1:0] sourceValid,
  input  wire logic       select,
  input  wire logic       outEnable,
  input  wire logic       delayCapacitorStrap,
  output logic            clkOut,
  output logic            clkOutN,
  output logic            switching
);
  src_stat_s     srcStat [2];
  switch_state_e state_r;
  logic          selMeta_r;
  logic          selSync_r;
  logic          curSel_r;
  logic          target_r;
  logic [3:0]    pulseCnt_r;
  logic          enMeta_r;
  logic          enSync_r;
  logic          gateOpen_r;
  logic          prevLvl_r;
  logic          clkOut_r;
  logic          clkOutN_r;
  logic [4:0]    newEdges_r;
  src_stat_s     oldStat;
  src_stat_s     newStat;
  logic          switchReq;
  logic          selLevel;
  logic          selFall;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_src
      failsafe_input_latch u_latch (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .srcLevel (clockSource[g]),
        .srcValid (sourceValid[g]),
        .stat     (srcStat[g])
      );
    end
  endgenerate

  // toggling but weak inputs pass as sampled; no runt filtering there
  assign oldStat   = srcStat[curSel_r];
  assign newStat   = srcStat[target_r];
  assign switchReq = (selSync_r != curSel_r);

  // two flops; only the second is used by decisions
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      selMeta_r <= 1'b0;
      selSync_r <= 1'b0;
      enMeta_r  <= 1'b0;
      enSync_r  <= 1'b0;
    end
    else
    begin
      selMeta_r <= select;
      selSync_r <= selMeta_r;
      enMeta_r  <= outEnable;
      enSync_r  <= enMeta_r;
    end
  end

  // reset is the power-on state: source 0, following, gate closed
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_r    <= ST_FOLLOW;
      curSel_r   <= 1'b0;
      target_r   <= 1'b0;
      pulseCnt_r <= 4'h0;
    end
    else if (delayCapacitorStrap)
    begin
      state_r  <= ST_FOLLOW;
      curSel_r <= selSync_r;
      target_r <= selSync_r;
    end
    else
    begin
      case (state_r)
        ST_FOLLOW:
        begin
          pulseCnt_r <= 4'h0;
          if (switchReq)
          begin
            target_r <= selSync_r;
            if (!oldStat.stuck)
              state_r <= ST_DRAIN;
            else if (oldStat.level)
              state_r <= ST_HOLD_HIGH;
            else
              state_r <= ST_HOLD_LOW;
          end
        end
        ST_DRAIN:
        begin
          // old clock dying mid-drain takes the stuck path
          if (oldStat.stuck)
          begin
            pulseCnt_r <= 4'h0;
            state_r    <= oldStat.level ? ST_HOLD_HIGH : ST_HOLD_LOW;
          end
          else if (oldStat.fall)
          begin
            if (pulseCnt_r == DRAIN_PULSES - 4'h1)
            begin
              pulseCnt_r <= 4'h0;
              state_r    <= ST_HOLD_LOW;
            end
            else
              pulseCnt_r <= pulseCnt_r + 4'h1;
          end
        end
        ST_HOLD_HIGH:
        begin
          // full new periods keep the stretched high phase long
          if (newStat.rise)
          begin
            if (pulseCnt_r == HOLD_PULSES - 4'h1)
            begin
              pulseCnt_r <= 4'h0;
              state_r    <= ST_HOLD_LOW;
            end
            else
              pulseCnt_r <= pulseCnt_r + 4'h1;
          end
        end
        default:
        begin
          // leave on a new falling edge so the handover starts low
          if (newStat.fall)
          begin
            if (pulseCnt_r == HOLD_PULSES - 4'h1)
            begin
              pulseCnt_r <= 4'h0;
              curSel_r   <= target_r;
              state_r    <= ST_FOLLOW;
            end
            else
              pulseCnt_r <= pulseCnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  always_comb
  begin
    if (delayCapacitorStrap)
      selLevel = srcStat[selSync_r].level;
    else
    begin
      case (state_r)
        ST_FOLLOW:    selLevel = oldStat.level;
        ST_DRAIN:     selLevel = oldStat.level;
        ST_HOLD_HIGH: selLevel = 1'b1;
        default:      selLevel = 1'b0;
      endcase
    end
  end

  assign selFall = prevLvl_r & ~selLevel;

  // gate changes only on a falling edge, so outputs switch while low
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      prevLvl_r  <= 1'b0;
      gateOpen_r <= 1'b0;
    end
    else
    begin
      prevLvl_r <= selLevel;
      if (selFall)
        gateOpen_r <= enSync_r;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      clkOut_r  <= OUT_RESET_LEVEL;
      clkOutN_r <= ~OUT_RESET_LEVEL;
    end
    else
    begin
      clkOut_r  <= selLevel & gateOpen_r;
      clkOutN_r <= ~(selLevel & gateOpen_r);
    end
  end

  // helper count of new-clock rises during a switchover
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      newEdges_r <= 5'h00;
    else if (state_r == ST_FOLLOW)
      newEdges_r <= 5'h00;
    else if (newStat.rise && newEdges_r != 5'h1F)
      newEdges_r <= newEdges_r + 5'h01;
  end

  assign clkOut    = clkOut_r;
  assign clkOutN   = clkOutN_r;
  assign switching = (state_r != ST_FOLLOW);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_comp_inverse: assert property (clkOutN_r == ~clkOut_r)
    else $error("complement output not inverse");
  a_gate_while_low: assert property (
    $changed(gateOpen_r) |-> !clkOut_r)
    else $error("gate changed while output high");
  a_closed_holds_low: assert property (
    !gateOpen_r |=> !clkOut_r)
    else $error("output high with gate closed");
  a_reopen_on_fall: assert property (
    $rose(gateOpen_r) |-> $past(selFall) && $past(enSync_r))
    else $error("gate opened without falling edge");
  a_sel_from_sync: assert property (
    $changed(curSel_r) |-> curSel_r == $past(selSync_r)
      || curSel_r == $past(target_r))
    else $error("selection not taken from synchronised select");
  a_running_drain: assert property (
    state_r == ST_FOLLOW && switchReq && !delayCapacitorStrap
      && !oldStat.stuck |=> state_r == ST_DRAIN)
    else $error("running switch did not drain");
  a_stuck_high_path: assert property (
    state_r == ST_FOLLOW && switchReq && !delayCapacitorStrap
      && oldStat.stuck && oldStat.level |=> state_r == ST_HOLD_HIGH
      ##0 clkOut_r == $past(clkOut_r))
    else $error("stuck high did not hold high");
  a_stuck_low_path: assert property (
    state_r == ST_FOLLOW && switchReq && !delayCapacitorStrap
      && oldStat.stuck && !oldStat.level |=> state_r == ST_HOLD_LOW)
    else $error("stuck low did not hold low");
  a_switch_bound: assert property (
    newEdges_r <= MAX_SWITCH_EDGES)
    else $error("switchover exceeded cycle bound");
  a_dead_input_stable: assert property (
    state_r == ST_FOLLOW && !delayCapacitorStrap && oldStat.stuck
      && !switchReq ##1 oldStat.stuck |=> $stable(clkOut_r))
    else $error("output moved with dead input");
  a_plain_mux: assert property (
    delayCapacitorStrap && gateOpen_r |=>
      clkOut_r == $past(srcStat[selSync_r].level))
    else $error("strapped mode not a plain multiplexer");

  c_running_switch: cover property (
    state_r == ST_DRAIN ##[1:200] state_r == ST_FOLLOW);
  c_stuck_high: cover property (
    state_r == ST_HOLD_HIGH ##[1:200] state_r == ST_FOLLOW);
  c_gate_cycle: cover property (
    $fell(gateOpen_r) ##[1:200] $rose(gateOpen_r));
endmodule : glitchless_clock_switchover
`default_nettype wire

// ==== bench/clock_source_model.sv ====
// behavioural pair of redundant clock sources in the sample domain
`default_nettype none
module clock_source_model
#(
  parameter int HALF0 = 4,
  parameter int HALF1 = 5
)
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [3:0] mode,
  output logic      [1:0] level,
  output logic      [1:0] valid
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt [2];
  // mode per source: 0 run, 1 stuck low, 2 stuck high, 3 collapsed
  // changes to modes 0-2 land on a phase boundary; mode 3 acts at once but drops valid, so no runt comes from here
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      level <= 2'h0;
      valid <= 2'h3;
      cnt   <= '{0, 0};
    end
    else
      for (int i = 0; i < 2; i++)
      begin
        if (mode[2*i+:2] == 2'h3)
        begin
          valid[i] <= 1'h0;
          level[i] <= ~level[i];
        end
        else if (cnt[i] >= (i ? HALF1 : HALF0) - 1)
        begin
          cnt[i]   <= 0;
          valid[i] <= 1'h1;
          level[i] <= (mode[2*i+:2] == 2'h0) ? ~level[i]
                                             : mode[2*i+1];
        end
        else
          cnt[i] <= cnt[i] + 1;
      end
  end
endmodule : clock_source_model
`default_nettype wire

// ==== bench/glitchless_clock_switchover_tb.sv ====
// self-checking bench for the glitchless clock switchover
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module glitchless_clock_switchover_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int H0 = 4;
  localparam int H1 = 5;
  logic       clk_sys;
  logic       reset;
  logic       select;
  logic       outEnable;
  logic       delayCapacitorStrap;
  logic [3:0] mode;
  logic [1:0] clockSource;
  logic [1:0] sourceValid;
  logic       clkOut;
  logic       clkOutN;
  logic       switching;
  logic       last;
  int         n_fail;
  int         checked;
  int         run;
  int         rises;

  glitchless_clock_switchover dut_u (
    .clk_sys(clk_sys), .reset(reset), .clockSource(clockSource),
    .sourceValid(sourceValid), .select(select), .outEnable(outEnable),
    .delayCapacitorStrap(delayCapacitorStrap), .clkOut(clkOut),
    .clkOutN(clkOutN), .switching(switching));
  clock_source_model #(.HALF0(H0), .HALF1(H1)) src_u (
    .clk_sys(clk_sys), .reset(reset), .mode(mode),
    .level(clockSource), .valid(sourceValid));

  initial
  begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  // every phase of the output must be at least a source half period
  // sampled mid-cycle, clear of the edge that launches the output
  always @(negedge clk_sys)
  begin
    `CHK("complement", ~clkOut, clkOutN)
    if (clkOut !== last)
    begin
      if (!delayCapacitorStrap && !reset)
        `CHK("phase width", 1'h1, run >= H0)
      rises += clkOut;
      run = 0;
    end
    run++;
    last = clkOut;
  end

  task cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task end_of_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // bounded wait; running out ends the run
  task waitSw(logic v, int lim);
    for (int i = 0; i < lim && switching !== v; i++)
      @(posedge clk_sys);
    if (switching !== v)
    begin
      `CHK("switching wait", v, switching)
      end_of_test();
    end
  endtask : waitSw

  // a window of four periods holds exactly four output rises
  task follow(int h, string nm);
    rises = 0;
    cyc(8 * h);
    `CHK(nm, 4, rises)
  endtask : follow

  task t_running();
    select <= 1'h1;
    waitSw(1'h1, 8);
    waitSw(1'h0, 34 * H1 + 8);
    follow(H1, "follow new clock");
    $display("running switch done");
  endtask : t_running

  task t_stuck();
    mode <= 4'h8;
    cyc(4 * H1);
    select <= 1'h0;
    waitSw(1'h1, 8);
    `CHK("hold high", 1'h1, clkOut)
    waitSw(1'h0, 34 * H0 + 8);
    follow(H0, "follow after high");
    mode <= 4'h1;
    cyc(4 * H1);
    select <= 1'h1;
    waitSw(1'h1, 8);
    rises = 0;
    waitSw(1'h0, 34 * H1 + 8);
    `CHK("held low", 0, rises)
    follow(H1, "follow after low");
    $display("stuck switch done");
  endtask : t_stuck

  // a collapsed input keeps its last valid level, here high
  task t_collapse();
    mode <= 4'h8;
    cyc(4 * H1);
    mode <= 4'hC;
    rises = 0;
    cyc(40);
    `CHK("dead input stable", 0, rises)
    select <= 1'h0;
    waitSw(1'h1, 8);
    `CHK("last level high", 1'h1, clkOut)
    waitSw(1'h0, 34 * H0 + 8);
    follow(H0, "follow after dead");
    $display("collapse switch done");
  endtask : t_collapse

  task t_enable();
    mode <= 4'h0;
    outEnable <= 1'h0;
    cyc(4 * H0);
    // gate is closed by now: a full window must stay low
    rises = 0;
    cyc(8 * H0);
    `CHK("gated rises", 0, rises)
    `CHK("gated low", 1'h0, clkOut)
    `CHK("gated complement", 1'h1, clkOutN)
    outEnable <= 1'h1;
    cyc(4 * H0);
    follow(H0, "resumed");
    $display("enable done");
  endtask : t_enable

  // plain mux: no sequence, so runts are tolerated here
  task t_strap();
    delayCapacitorStrap <= 1'h1;
    select <= 1'h1;
    for (int i = 0; i < 20; i++)
    begin
      cyc(1);
      `CHK("no sequence", 1'h0, switching)
    end
    follow(H1, "plain mux");
    $display("strap done");
  endtask : t_strap

  initial
  begin
    reset = 1'h1;
    select = 1'h0;
    outEnable = 1'h1;
    delayCapacitorStrap = 1'h0;
    mode = 4'h0;
    n_fail = 0;
    checked = 0;
    cyc(19);
    `CHK("reset out", 1'h0, clkOut)
    `CHK("reset switching", 1'h0, switching)
    cyc(1);
    reset <= 1'h0;
    cyc(10);
    follow(H0, "follow source zero");
    $display("reset done");
    t_running();
    t_stuck();
    t_collapse();
    t_enable();
    t_strap();
    end_of_test();
  end
endmodule : glitchless_clock_switchover_tb
`default_nettype wire
